// >>> rtl/pmii_defines.svh
// Register offsets, field positions, reset values and timing counts for the MII port block
`ifndef PMII_DEFINES_SVH
`define PMII_DEFINES_SVH
// Summary of operation
// - Transmit nibble and controls are captured on each transmit clock rising edge.
// - In symbol mode the transmit error input becomes the fifth transmit data bit.
// - Transmitter is enabled while the transmit enable input is high.
// - At 100 Mbps a high transmit error sends Halt; ignored at 10 Mbps.
// - Transmit clock runs at 20 MHz for 100 Mbps, 2.5 MHz for 10 Mbps.
// - Received nibbles change synchronously with the receive clock.
// - In symbol mode the receive error output carries the fifth receive data bit.
// - Carrier sense rises at once; half duplex counts transmit too, full only receive.
// - Carrier sense falls on loss of carrier, on a receive clock edge.
// - Collision is high at once while receive and transmit are both active.
// - Collision stays low throughout full duplex.
// - Receive data valid is high while the received code maps to valid data.
// - At 10 Mbps data valid rises with delimiter nibble 5 of 5D, holds to end.
// - Receive error is high for an invalid code group or an unlocked PLL.
// - At 10 Mbps receive error flags a delimiter A2 instead of 5D.
// - A continuous receive clock times receive outputs at 20 or 2.5 MHz.
// - Management data moves over one bidirectional line timed by the management clock.
// - With interrupt enable set, open-drain interrupt pulls low on status change.
// - Reading the interrupt status register releases the pending interrupt.
// - Each port answers at management address base plus its port number.
// - A port resets on the reset input or its control reset bit.
`define PMII_REG_CTRL       5'h00
`define PMII_REG_CFG        5'h10
`define PMII_REG_INTEN      5'h12
`define PMII_REG_INTSTAT    5'h13
`define PMII_CTRL_RESET     15
`define PMII_CTRL_SPEED     13
`define PMII_CTRL_DUPLEX    8
`define PMII_CFG_SYMBOL     11
`define PMII_INTEN_BIT      1
`define PMII_INTSTAT_LINK   2
`define PMII_RST_SPEED100   1'b1
`define PMII_RST_FULLDUP    1'b0
`define PMII_RST_SYMBOL     1'b0
`define PMII_RST_INTEN      1'b0
`define PMII_CLK_PERIOD_NS  25
`define PMII_MII100_HALF_NS 20
`define PMII_MII10_HALF_NS  200
`define PMII_HALF100_CYC    (((`PMII_MII100_HALF_NS) / (`PMII_CLK_PERIOD_NS)) < 1 ? 1 : \
	((`PMII_MII100_HALF_NS) / (`PMII_CLK_PERIOD_NS)))
`define PMII_HALF10_CYC     (((`PMII_MII10_HALF_NS) / (`PMII_CLK_PERIOD_NS)) < 1 ? 1 : \
	((`PMII_MII10_HALF_NS) / (`PMII_CLK_PERIOD_NS)))
`define PMII_PREAMBLE_ONES  6'd32
`define PMII_NIB_PRE        4'h5
`define PMII_NIB_SFD        4'hd
`define PMII_NIB_BAD_HI     4'ha
`define PMII_NIB_BAD_LO     4'h2
`define PMII_OP_READ        2'b10
`define PMII_OP_WRITE       2'b01
`define PMII_HDR_BITS       4'd13
`endif

// >>> rtl/pmii_pkg.sv
// Types shared by the MII port block
package pmii_pkg;
	typedef enum logic [4:0] {
		PMII_PRE = 5'b00001,
		PMII_HDR = 5'b00010,
		PMII_TA  = 5'b00100,
		PMII_RD  = 5'b01000,
		PMII_WR  = 5'b10000
	} pmii_mdio_state_type;
endpackage

// >>> rtl/pmii_port_if.sv
// Six-port MII interface with management serial slave and register port
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "pmii_defines.svh"
module pmii_port_if
	import pmii_pkg::*;
#(
	parameter int NP = 6
)(
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	input  wire logic [4:0]          strapBaseAddr,
	input  wire logic [7:0]          regAddr,
	input  wire logic [15:0]         regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [15:0]         regRdData,
	input  wire logic [NP-1:0][3:0]  macTxData,
	input  wire logic [NP-1:0]       macTxEn,
	input  wire logic [NP-1:0]       macTxErOrSymbolBit4,
	output logic      [NP-1:0]       macTxClk,
	output logic      [NP-1:0]       macRxClk,
	output logic      [NP-1:0][3:0]  macRxData,
	output logic      [NP-1:0]       macRxDv,
	output logic      [NP-1:0]       macRxErOrSymbolBit4,
	output logic      [NP-1:0]       macCrs,
	output logic      [NP-1:0]       macCol,
	output logic      [NP-1:0][4:0]  lineTxData,
	output logic      [NP-1:0]       lineTxEn,
	output logic      [NP-1:0]       lineTxHalt,
	input  wire logic [NP-1:0]       lineRxStrobe,
	input  wire logic [NP-1:0][4:0]  lineRxSym,
	input  wire logic [NP-1:0]       lineRxCodeErr,
	input  wire logic [NP-1:0]       lineRxActive,
	input  wire logic [NP-1:0]       linePllLocked,
	input  wire logic [NP-1:0]       lineLinkUp,
	input  wire logic                mdcIn,
	input  wire logic                mdioIn,
	output logic                     mdioOut,
	output logic                     mdioOe,
	output logic                     mgmtInterruptNOut,
	output logic                     mgmtInterruptNOe
);
	localparam logic [3:0] HALF100 = 4'(`PMII_HALF100_CYC);
	localparam logic [3:0] HALF10  = 4'(`PMII_HALF10_CYC);

	logic [4:0]          baseAddr;
	logic                strapDone;
	logic [NP-1:0]       cfgSpeed100;
	logic [NP-1:0]       cfgFullDup;
	logic [NP-1:0]       cfgSymbol;
	logic [NP-1:0]       cfgIntEn;
	logic [NP-1:0]       statLinkChg;
	logic [2:0]          mdcSync;
	logic [2:0]          mdioSync;
	logic                mdcStable;
	logic                mdioStable;
	logic                mdcRise;
	pmii_mdio_state_type mdState;
	logic [5:0]          mdOnes;
	logic [3:0]          mdCnt;
	logic [12:0]         mdHdr;
	logic [15:0]         mdShift;
	logic [2:0]          mdPort;
	logic [4:0]          mdReg;
	logic                mdWr;
	logic                mdRd;
	logic                mdOutReg;
	logic                mdOeReg;
	logic                wrEn;
	logic [2:0]          wrPort;
	logic [4:0]          wrReg;
	logic [15:0]         wrData;
	logic [12:0]         next_mdHdr;
	logic [4:0]          hdrPhyOff;
	logic                hdrHit;

	function automatic logic [15:0] readMux(input logic [2:0] p, input logic [4:0] r);
		logic [15:0] v;
		v = 16'h0000;
		if (32'(p) < NP)
		begin
			if (r == `PMII_REG_CTRL)
			begin
				v[`PMII_CTRL_SPEED] = cfgSpeed100[p];
				v[`PMII_CTRL_DUPLEX] = cfgFullDup[p];
			end
			else if (r == `PMII_REG_CFG)
				v[`PMII_CFG_SYMBOL] = cfgSymbol[p];
			else if (r == `PMII_REG_INTEN)
				v[`PMII_INTEN_BIT] = cfgIntEn[p];
			else if (r == `PMII_REG_INTSTAT)
				v[`PMII_INTSTAT_LINK] = statLinkChg[p];
		end
		return v;
	endfunction

	// Strap is caught once after reset release
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			baseAddr <= 5'h00;
			strapDone <= 1'b0;
		end
		else if (clkEn && !strapDone)
		begin
			baseAddr <= strapBaseAddr;
			strapDone <= 1'b1;
		end
	end

	// Management pins pass three flops; a level counts once the last two agree
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mdcSync <= 3'h0;
			mdioSync <= 3'h0;
			mdcStable <= 1'b0;
			mdioStable <= 1'b0;
		end
		else if (clkEn)
		begin
			mdcSync <= {mdcSync[1:0], mdcIn};
			mdioSync <= {mdioSync[1:0], mdioIn};
			if (mdcSync[2] == mdcSync[1])
				mdcStable <= mdcSync[2];
			if (mdioSync[2] == mdioSync[1])
				mdioStable <= mdioSync[2];
		end
	end

	assign mdcRise = (mdcSync[2] == mdcSync[1]) && mdcSync[2] && !mdcStable;
	assign next_mdHdr = {mdHdr[11:0], mdioStable};
	assign hdrPhyOff = next_mdHdr[9:5] - baseAddr;
	assign hdrHit = next_mdHdr[12] && (32'(hdrPhyOff) < NP);

	// Serial management frame slave
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mdState <= PMII_PRE;
			mdOnes <= 6'h00;
			mdCnt <= 4'h0;
			mdHdr <= 13'h0000;
			mdShift <= 16'h0000;
			mdPort <= 3'h0;
			mdReg <= 5'h00;
			mdWr <= 1'b0;
			mdRd <= 1'b0;
			mdOutReg <= 1'b0;
			mdOeReg <= 1'b0;
		end
		else if (clkEn)
		begin
			mdWr <= 1'b0;
			mdRd <= 1'b0;
			if (mdcRise)
			begin
				case (mdState)
					PMII_PRE:
					begin
						mdOeReg <= 1'b0;
						if (mdioStable)
						begin
							if (mdOnes != `PMII_PREAMBLE_ONES)
								mdOnes <= mdOnes + 6'h01;
						end
						else if (mdOnes == `PMII_PREAMBLE_ONES)
						begin
							mdState <= PMII_HDR;
							mdCnt <= 4'h0;
							mdOnes <= 6'h00;
						end
						else
							mdOnes <= 6'h00;
					end
					PMII_HDR:
					begin
						mdHdr <= next_mdHdr;
						mdCnt <= mdCnt + 4'h1;
						if (mdCnt == `PMII_HDR_BITS - 4'h1)
						begin
							mdCnt <= 4'h0;
							mdPort <= hdrPhyOff[2:0];
							mdReg <= next_mdHdr[4:0];
							if (hdrHit && (next_mdHdr[11:10] == `PMII_OP_READ))
							begin
								mdShift <= readMux(hdrPhyOff[2:0], next_mdHdr[4:0]);
								mdRd <= 1'b1;
								mdState <= PMII_TA;
							end
							else if (hdrHit && (next_mdHdr[11:10] == `PMII_OP_WRITE))
							begin
								mdOeReg <= 1'b0;
								mdState <= PMII_TA;
								mdHdr <= 13'h0000;
							end
							else
								mdState <= PMII_PRE;
						end
					end
					PMII_TA:
					begin
						mdCnt <= mdCnt + 4'h1;
						if (mdCnt == 4'h1)
						begin
							mdCnt <= 4'h0;
							if (mdHdr[11:10] == `PMII_OP_READ)
							begin
								mdOeReg <= 1'b1;
								mdOutReg <= 1'b0;
								mdState <= PMII_RD;
							end
							else
								mdState <= PMII_WR;
						end
					end
					PMII_RD:
					begin
						mdOutReg <= mdShift[15];
						mdShift <= {mdShift[14:0], 1'b0};
						mdCnt <= mdCnt + 4'h1;
						if (mdCnt == 4'hf)
							mdState <= PMII_PRE;
					end
					PMII_WR:
					begin
						mdShift <= {mdShift[14:0], mdioStable};
						mdCnt <= mdCnt + 4'h1;
						if (mdCnt == 4'hf)
						begin
							mdWr <= 1'b1;
							mdState <= PMII_PRE;
						end
					end
					default:
						mdState <= PMII_PRE;
				endcase
			end
		end
	end

	// Register port wins a same-cycle collision with a management write
	assign wrEn = regWr || mdWr;
	assign wrPort = regWr ? regAddr[7:5] : mdPort;
	assign wrReg = regWr ? regAddr[4:0] : mdReg;
	assign wrData = regWr ? regWrData : mdShift;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= 16'h0000;
		else if (clkEn)
			regRdData <= regRd ? readMux(regAddr[7:5], regAddr[4:0]) : 16'h0000;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mdioOut <= 1'b0;
			mdioOe <= 1'b0;
			mgmtInterruptNOut <= 1'b0;
			mgmtInterruptNOe <= 1'b0;
		end
		else if (clkEn)
		begin
			mdioOut <= mdOutReg;
			mdioOe <= mdOeReg;
			mgmtInterruptNOe <= |(cfgIntEn & statLinkChg);
		end
	end

	genvar i;
	generate
		for (i = 0; i < NP; i++)
		begin : gPort
			logic       speed100;
			logic       fullDup;
			logic       symbol;
			logic       intEn;
			logic       linkChg;
			logic       linkPrev;
			logic       softRst;
			logic       wrHit;
			logic       rdClr;
			logic [3:0] divCnt;
			logic       txClkQ;
			logic       rxClkQ;
			logic       txRise;
			logic       rxFall;
			logic [4:0] txDataQ;
			logic       txEnQ;
			logic       txHaltQ;
			logic [4:0] nibNew;
			logic [4:0] nibOld;
			logic       errNew;
			logic       errOld;
			logic       dv10;
			logic [3:0] rxDataQ;
			logic       rxDvQ;
			logic       rxErQ;
			logic       crsQ;
			logic       colQ;

			assign wrHit = wrEn && (32'(wrPort) == i);
			assign rdClr = (regRd && (32'(regAddr[7:5]) == i) && regAddr[4:0] == `PMII_REG_INTSTAT)
				|| (mdRd && (32'(mdPort) == i) && mdReg == `PMII_REG_INTSTAT);

			// Configuration; a write of the reset bit restores defaults next cycle
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					speed100 <= `PMII_RST_SPEED100;
					fullDup <= `PMII_RST_FULLDUP;
					symbol <= `PMII_RST_SYMBOL;
					intEn <= `PMII_RST_INTEN;
					softRst <= 1'b0;
				end
				else if (clkEn)
				begin
					softRst <= 1'b0;
					if (softRst)
					begin
						speed100 <= `PMII_RST_SPEED100;
						fullDup <= `PMII_RST_FULLDUP;
						symbol <= `PMII_RST_SYMBOL;
						intEn <= `PMII_RST_INTEN;
					end
					else if (wrHit && wrReg == `PMII_REG_CTRL)
					begin
						speed100 <= wrData[`PMII_CTRL_SPEED];
						fullDup <= wrData[`PMII_CTRL_DUPLEX];
						softRst <= wrData[`PMII_CTRL_RESET];
					end
					else if (wrHit && wrReg == `PMII_REG_CFG)
						symbol <= wrData[`PMII_CFG_SYMBOL];
					else if (wrHit && wrReg == `PMII_REG_INTEN)
						intEn <= wrData[`PMII_INTEN_BIT];
				end
			end

			// Link change is sticky; a new change beats the clear on read
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					linkChg <= 1'b0;
					linkPrev <= 1'b0;
				end
				else if (clkEn)
				begin
					linkPrev <= lineLinkUp[i];
					if (lineLinkUp[i] != linkPrev)
						linkChg <= 1'b1;
					else if (rdClr || softRst)
						linkChg <= 1'b0;
				end
			end

			// One divider per port makes both continuous port clocks
			assign txRise = (divCnt == 4'h0) && !txClkQ;
			assign rxFall = (divCnt == 4'h0) && rxClkQ;
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					divCnt <= 4'h0;
					txClkQ <= 1'b0;
					rxClkQ <= 1'b0;
				end
				else if (clkEn)
				begin
					if (divCnt == 4'h0)
					begin
						divCnt <= (speed100 ? HALF100 : HALF10) - 4'h1;
						txClkQ <= !txClkQ;
						rxClkQ <= !rxClkQ;
					end
					else
						divCnt <= divCnt - 4'h1;
				end
			end

			// Transmit side sampled at the edge that raises the transmit clock
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					txDataQ <= 5'h00;
					txEnQ <= 1'b0;
					txHaltQ <= 1'b0;
				end
				else if (clkEn)
				begin
					if (softRst)
					begin
						txDataQ <= 5'h00;
						txEnQ <= 1'b0;
						txHaltQ <= 1'b0;
					end
					else if (txRise)
					begin
						txDataQ <= {symbol & macTxErOrSymbolBit4[i], macTxData[i]};
						txEnQ <= macTxEn[i];
						txHaltQ <= macTxErOrSymbolBit4[i] & speed100 & !symbol;
					end
				end
			end

			// Two-deep nibble pipe lets the delimiter be seen before its first nibble leaves
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					nibNew <= 5'h00;
					nibOld <= 5'h00;
					errNew <= 1'b0;
					errOld <= 1'b0;
				end
				else if (clkEn)
				begin
					if (lineRxStrobe[i])
					begin
						nibNew <= lineRxSym[i];
						nibOld <= nibNew;
						errNew <= lineRxCodeErr[i];
						errOld <= errNew;
					end
				end
			end

			// Receive outputs change on the receive clock falling edge
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					rxDataQ <= 4'h0;
					rxDvQ <= 1'b0;
					rxErQ <= 1'b0;
					dv10 <= 1'b0;
				end
				else if (clkEn)
				begin
					if (softRst)
					begin
						rxDataQ <= 4'h0;
						rxDvQ <= 1'b0;
						rxErQ <= 1'b0;
						dv10 <= 1'b0;
					end
					else if (rxFall)
					begin
						rxDataQ <= nibOld[3:0];
						if (!lineRxActive[i])
						begin
							dv10 <= 1'b0;
							rxDvQ <= 1'b0;
							rxErQ <= symbol & nibOld[4];
						end
						else if (symbol)
						begin
							rxDvQ <= 1'b1;
							rxErQ <= nibOld[4];
						end
						else if (speed100)
						begin
							rxDvQ <= !errOld;
							rxErQ <= errOld | !linePllLocked[i];
						end
						else
						begin
							if (nibOld[3:0] == `PMII_NIB_PRE && nibNew[3:0] == `PMII_NIB_SFD)
							begin
								dv10 <= 1'b1;
								rxDvQ <= 1'b1;
							end
							else
								rxDvQ <= dv10;
							rxErQ <= (nibOld[3:0] == `PMII_NIB_BAD_HI
								&& nibNew[3:0] == `PMII_NIB_BAD_LO && !dv10)
								| !linePllLocked[i];
						end
					end
				end
			end

			// Carrier rises at once, falls only on a receive clock edge
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					crsQ <= 1'b0;
					colQ <= 1'b0;
				end
				else if (clkEn)
				begin
					if (lineRxActive[i] || (txEnQ && !fullDup))
						crsQ <= 1'b1;
					else if (rxFall)
						crsQ <= 1'b0;
					colQ <= lineRxActive[i] && txEnQ && !fullDup;
				end
			end

			assign cfgSpeed100[i] = speed100;
			assign cfgFullDup[i] = fullDup;
			assign cfgSymbol[i] = symbol;
			assign cfgIntEn[i] = intEn;
			assign statLinkChg[i] = linkChg;
			assign macTxClk[i] = txClkQ;
			assign macRxClk[i] = rxClkQ;
			assign lineTxData[i] = txDataQ;
			assign lineTxEn[i] = txEnQ;
			assign lineTxHalt[i] = txHaltQ;
			assign macRxData[i] = rxDataQ;
			assign macRxDv[i] = rxDvQ;
			assign macRxErOrSymbolBit4[i] = rxErQ;
			assign macCrs[i] = crsQ;
			assign macCol[i] = colQ;
		end
	endgenerate
endmodule // pmii_port_if

// >>> tb/pmii_mgmt_station.sv
// Management station model for the serial management pins
`timescale 1ns/10ps
module pmii_mgmt_station (
	input  wire logic core_clk,
	input  wire logic mdioLine,
	output logic      mdc,
	output logic      mdioDrv,
	output logic      mdioDrvOe
);
	initial
	begin
		mdc = 1'b0;
		mdioDrv = 1'b1;
		mdioDrvOe = 1'b0;
	end
	// Four core cycles a phase keeps the clock near 5 MHz; it stands low between frames
	task automatic pulse();
		repeat (4) @(posedge core_clk);
		mdc <= 1'b1;
		repeat (4) @(posedge core_clk);
		mdc <= 1'b0;
	endtask
	task automatic bitOut(input logic b);
		@(posedge core_clk);
		mdioDrvOe <= 1'b1;
		mdioDrv <= b;
		pulse();
	endtask
	task automatic header(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg);
		logic [13:0] h;
		int          i;
		h = {2'b01, op, phy, rg};
		for (i = 0; i < 32; i++)
			bitOut(1'b1);
		for (i = 13; i >= 0; i--)
			bitOut(h[i]);
	endtask
	task automatic readReg(input logic [4:0] phy, rg, output logic [15:0] d);
		int i;
		header(2'b10, phy, rg);
		@(posedge core_clk);
		mdioDrvOe <= 1'b0;
		pulse();
		pulse();
		// Sample on the third core clock fall of the low phase, after the device has shifted the bit out
		for (i = 15; i >= 0; i--)
		begin
			pulse();
			repeat (3) @(negedge core_clk);
			d[i] = mdioLine;
		end
		pulse();
	endtask
	task automatic writeReg(input logic [4:0] phy, rg, input logic [15:0] d);
		logic [17:0] w;
		int          i;
		w = {2'b10, d};
		header(2'b01, phy, rg);
		for (i = 17; i >= 0; i--)
			bitOut(w[i]);
		@(posedge core_clk);
		mdioDrvOe <= 1'b0;
	endtask
endmodule // pmii_mgmt_station

// >>> tb/pmii_port_if_properties.sv
// Concurrent checks on the port zero and management pins
`timescale 1ns/10ps
`include "pmii_defines.svh"
module pmii_port_if_properties
	import pmii_pkg::*;
#(
	parameter int NP = 6
)(
	input wire logic               core_clk,
	input wire logic               rst_n,
	input wire logic [7:0]         regAddr,
	input wire logic               regRd,
	input wire logic [NP-1:0][3:0] macTxData,
	input wire logic [NP-1:0]      macTxEn,
	input wire logic [NP-1:0]      macTxErOrSymbolBit4,
	input wire logic [NP-1:0]      macTxClk,
	input wire logic [NP-1:0]      macRxClk,
	input wire logic [NP-1:0][3:0] macRxData,
	input wire logic [NP-1:0]      macCrs,
	input wire logic [NP-1:0]      macCol,
	input wire logic [NP-1:0][4:0] lineTxData,
	input wire logic [NP-1:0]      lineTxEn,
	input wire logic [NP-1:0]      lineTxHalt,
	input wire logic [NP-1:0]      lineRxActive,
	input wire logic               mdioOe,
	input wire logic               mgmtInterruptNOut,
	input wire logic               mgmtInterruptNOe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	tx_en_take_a: assert property ($rose(macTxClk[0]) |-> lineTxEn[0] == $past(macTxEn[0]))
		else $error("tx enable not taken at clock rise");
	tx_en_sync_a: assert property ($changed(lineTxEn[0]) |-> $rose(macTxClk[0]))
		else $error("tx enable moved off clock rise");
	tx_data_take_a: assert property ($rose(macTxClk[0]) |-> lineTxData[0][3:0] == $past(macTxData[0]))
		else $error("tx nibble not taken at clock rise");
	tx_halt_cause_a: assert property ($rose(macTxClk[0]) && lineTxHalt[0] |->
		$past(macTxErOrSymbolBit4[0]) && !lineTxData[0][4])
		else $error("halt without tx error");
	col_cause_a: assert property (macCol[0] |-> $past(lineRxActive[0] && lineTxEn[0]))
		else $error("collision without both activities");
	crs_rise_a: assert property (lineRxActive[0] |=> macCrs[0])
		else $error("carrier sense late");
	crs_fall_a: assert property ($fell(macCrs[0]) |-> !macRxClk[0])
		else $error("carrier sense fell off rx clock fall");
	rx_data_sync_a: assert property ($changed(macRxData[0]) |-> !macRxClk[0])
		else $error("rx nibble moved off rx clock fall");
	int_pin_low_a: assert property (!mgmtInterruptNOut)
		else $error("interrupt pin driven high");
	int_read_clear_a: assert property (regRd && regAddr == {3'd0, `PMII_REG_INTSTAT} |->
		##[1:4] !mgmtInterruptNOe)
		else $error("interrupt kept after status read");
	cover property (macCol[0]);
	cover property ($rose(mgmtInterruptNOe));
	cover property ($rose(mdioOe));
endmodule // pmii_port_if_properties
bind pmii_port_if pmii_port_if_properties #(.NP(NP)) u_pmii_port_if_properties (
	.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regRd(regRd),
	.macTxData(macTxData), .macTxEn(macTxEn), .macTxErOrSymbolBit4(macTxErOrSymbolBit4),
	.macTxClk(macTxClk), .macRxClk(macRxClk), .macRxData(macRxData), .macCrs(macCrs),
	.macCol(macCol), .lineTxData(lineTxData), .lineTxEn(lineTxEn), .lineTxHalt(lineTxHalt),
	.lineRxActive(lineRxActive), .mdioOe(mdioOe), .mgmtInterruptNOut(mgmtInterruptNOut),
	.mgmtInterruptNOe(mgmtInterruptNOe)
);

// >>> tb/pmii_port_if_tb.sv
// Self-checking bench for the MII port block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module pmii_port_if_tb;
	import pmii_pkg::*;
	localparam int NP = 6;
	logic               core_clk, rst_n, regWr, regRd, mdc, stDrv, stOe;
	logic               mdioOut, mdioOe, intOut, intOe;
	logic [7:0]         regAddr;
	logic [15:0]        regWrData, regRdData, rdv;
	logic [NP-1:0][3:0] macTxData, macRxData;
	logic [NP-1:0][4:0] lineTxData, lineRxSym;
	logic [NP-1:0]      macTxEn, macTxEr, macTxClk, macRxClk, macRxDv, macRxEr;
	logic [NP-1:0]      macCrs, macCol, lineTxEn, lineTxHalt, rxStb, rxErr, rxAct, pll, linkUp;
	int                 n_errors, num_checks, k;
	// Open-drain style wires with pull-ups
	wire mdioLine = (mdioOe ? mdioOut : 1'b1) & (stOe ? stDrv : 1'b1);
	wire intPinN = intOe ? intOut : 1'b1;
	pmii_port_if #(.NP(NP)) u_pmii_port_if (
		.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .strapBaseAddr(5'h08),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .macTxData(macTxData), .macTxEn(macTxEn),
		.macTxErOrSymbolBit4(macTxEr), .macTxClk(macTxClk), .macRxClk(macRxClk),
		.macRxData(macRxData), .macRxDv(macRxDv), .macRxErOrSymbolBit4(macRxEr),
		.macCrs(macCrs), .macCol(macCol), .lineTxData(lineTxData), .lineTxEn(lineTxEn),
		.lineTxHalt(lineTxHalt), .lineRxStrobe(rxStb), .lineRxSym(lineRxSym),
		.lineRxCodeErr(rxErr), .lineRxActive(rxAct), .linePllLocked(pll),
		.lineLinkUp(linkUp), .mdcIn(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
		.mdioOe(mdioOe), .mgmtInterruptNOut(intOut), .mgmtInterruptNOe(intOe)
	);
	pmii_mgmt_station u_pmii_mgmt_station (
		.core_clk(core_clk), .mdioLine(mdioLine), .mdc(mdc), .mdioDrv(stDrv),
		.mdioDrvOe(stOe)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		d = regRdData;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic waitTx(input logic v);
		int i;
		@(negedge core_clk);
		for (i = 0; i < 40 && macTxClk[0] !== v; i++)
			@(negedge core_clk);
	endtask
	// Drive just after a high phase is seen so the next rise takes the values
	task automatic txStep(input logic [3:0] d, input logic en, er);
		waitTx(1'b1);
		@(posedge core_clk);
		macTxData[0] <= d;
		macTxEn[0] <= en;
		macTxEr[0] <= er;
		waitTx(1'b0);
		waitTx(1'b1);
	endtask
	task automatic rxFeed(input logic [4:0] s, input logic e, input int gap);
		@(posedge core_clk);
		rxStb[0] <= 1'b1;
		lineRxSym[0] <= s;
		rxErr[0] <= e;
		@(posedge core_clk);
		rxStb[0] <= 1'b0;
		repeat (gap) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic clkRate(input int etx, erx);
		int   i, t, r;
		logic pt, pr;
		t = 0;
		r = 0;
		settle(16);
		pt = macTxClk[0];
		pr = macRxClk[0];
		for (i = 0; i < 64; i++)
		begin
			@(negedge core_clk);
			if (macTxClk[0] === 1'b1 && pt === 1'b0)
				t++;
			if (macRxClk[0] === 1'b1 && pr === 1'b0)
				r++;
			pt = macTxClk[0];
			pr = macRxClk[0];
		end
		`CHK("txclk rises", etx, t)
		`CHK("rxclk rises", erx, r)
	endtask
	// Watchdog: the whole sequence needs well under 10000 cycles
	initial
	begin
		repeat (40000) @(posedge core_clk);
		n_errors++;
		summarize();
	end
	initial
	begin
		n_errors = 0;
		num_checks = 0;
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		macTxData = '0;
		macTxEn = '0;
		macTxEr = '0;
		rxStb = '0;
		lineRxSym = '0;
		rxErr = '0;
		rxAct = '0;
		pll = '1;
		linkUp = '0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(8'h00, rdv);
		`CHK("ctrl", 16'h2000, rdv)
		rd(8'h05, rdv);
		`CHK("unmapped", 16'h0000, rdv)
		rd(8'hc0, rdv);
		`CHK("port6", 16'h0000, rdv)
		wr(8'h00, 16'h0100);
		rd(8'h00, rdv);
		`CHK("ctrl wr", 16'h0100, rdv)
		wr(8'h00, 16'h8000);
		rd(8'h00, rdv);
		`CHK("soft rst", 16'h2000, rdv)
		clkRate(32, 32);
		txStep(4'h6, 1'b1, 1'b1);
		`CHK("txen", 1'b1, lineTxEn[0])
		`CHK("txdata", 5'h06, lineTxData[0])
		`CHK("halt", 1'b1, lineTxHalt[0])
		wr(8'h10, 16'h0800);
		txStep(4'h6, 1'b1, 1'b1);
		`CHK("crs tx", 1'b1, macCrs[0])
		`CHK("txbit4", 5'h16, lineTxData[0])
		`CHK("halt sym", 1'b0, lineTxHalt[0])
		wr(8'h10, 16'h0000);
		wr(8'h00, 16'h0000);
		txStep(4'h9, 1'b1, 1'b1);
		`CHK("tx10", 5'h09, lineTxData[0])
		`CHK("halt10", 1'b0, lineTxHalt[0])
		clkRate(4, 4);
		@(posedge core_clk);
		rxAct[0] <= 1'b1;
		txStep(4'h9, 1'b1, 1'b0);
		`CHK("col", 1'b1, macCol[0])
		wr(8'h00, 16'h0100);
		txStep(4'h9, 1'b1, 1'b0);
		`CHK("col fd", 1'b0, macCol[0])
		@(posedge core_clk);
		rxAct[0] <= 1'b0;
		settle(40);
		`CHK("crs fd", 1'b0, macCrs[0])
		txStep(4'h0, 1'b0, 1'b0);
		@(posedge core_clk);
		rxAct[0] <= 1'b1;
		for (k = 0; k < 3; k++)
			rxFeed(5'h05, 1'b0, 20);
		rxFeed(5'h0d, 1'b0, 20);
		`CHK("dv sfd", 1'b1, macRxDv[0])
		rxFeed(5'h03, 1'b0, 20);
		`CHK("dv hold", 1'b1, macRxDv[0])
		`CHK("rxdata", 4'hd, macRxData[0])
		@(posedge core_clk);
		rxAct[0] <= 1'b0;
		settle(40);
		`CHK("dv end", 1'b0, macRxDv[0])
		`CHK("crs end", 1'b0, macCrs[0])
		@(posedge core_clk);
		rxAct[0] <= 1'b1;
		rxFeed(5'h05, 1'b0, 20);
		rxFeed(5'h0a, 1'b0, 20);
		rxFeed(5'h02, 1'b0, 20);
		`CHK("er a2", 1'b1, macRxEr[0])
		`CHK("dv a2", 1'b0, macRxDv[0])
		wr(8'h00, 16'h2000);
		for (k = 0; k < 3; k++)
			rxFeed(5'h07, 1'b0, 4);
		`CHK("rx100", 4'h7, macRxData[0])
		`CHK("dv100", 1'b1, macRxDv[0])
		`CHK("er100", 1'b0, macRxEr[0])
		rxFeed(5'h07, 1'b1, 4);
		rxFeed(5'h07, 1'b1, 4);
		`CHK("dv code", 1'b0, macRxDv[0])
		`CHK("er code", 1'b1, macRxEr[0])
		@(posedge core_clk);
		pll[0] <= 1'b0;
		rxFeed(5'h07, 1'b0, 4);
		rxFeed(5'h07, 1'b0, 4);
		`CHK("er pll", 1'b1, macRxEr[0])
		@(posedge core_clk);
		pll[0] <= 1'b1;
		wr(8'h10, 16'h0800);
		rxFeed(5'h1a, 1'b0, 4);
		rxFeed(5'h1a, 1'b0, 4);
		`CHK("rx sym", 4'ha, macRxData[0])
		`CHK("rxbit4", 1'b1, macRxEr[0])
		wr(8'h10, 16'h0000);
		@(posedge core_clk);
		rxAct[0] <= 1'b0;
		wr(8'h12, 16'h0002);
		@(posedge core_clk);
		linkUp[0] <= 1'b1;
		settle(5);
		`CHK("int on", 1'b0, intPinN)
		rd(8'h13, rdv);
		`CHK("intstat", 16'h0004, rdv)
		settle(5);
		`CHK("int off", 1'b1, intPinN)
		wr(8'h12, 16'h0000);
		@(posedge core_clk);
		linkUp[0] <= 1'b0;
		settle(5);
		`CHK("int mask", 1'b1, intPinN)
		rd(8'h13, rdv);
		`CHK("sticky", 16'h0004, rdv)
		rd(8'h13, rdv);
		`CHK("cleared", 16'h0000, rdv)
		u_pmii_mgmt_station.readReg(5'h09, 5'h00, rdv);
		`CHK("mdio rd", 16'h2000, rdv)
		u_pmii_mgmt_station.writeReg(5'h0a, 5'h10, 16'h0800);
		rd(8'h50, rdv);
		`CHK("mdio wr", 16'h0800, rdv)
		u_pmii_mgmt_station.readReg(5'h0e, 5'h00, rdv);
		`CHK("mdio far", 16'hffff, rdv)
		summarize();
	end
endmodule // pmii_port_if_tb
